// *** hw/tsc_ctrl.sv ***
// Touch controller settings logic with AXI4-Lite registers, baseline filters and conversion sequencing.
//
// Functional notes
// - Report click apart from touch on deep drop.
// - Transmitter bias field in settings zero.
// - Tuning hides windows unless streaming enabled.
// - Ready handshake forces a window any time.
// - Reseed loads averages with counts plus eight.
// - Averages step toward counts until equal, except proximity during an event.
// - Reseed clears proximity and touch states.
// - Retune when average leaves target band.
// - Retune request bit self-clears on start.
// - Retune clears proximity, touch, click, halt.
// - Click enable; click status readable.
// - Band select chooses eighth or quarter.
// - Force sleep reseeds proximity, wakes on movement.
// - Projected proximity charging mode output.
// - Combined receive charges channels one to nine.
// - Conversion halt stops all conversions.
// - Halted conversions run 512 ms wake timer.
// - Free-run starts conversions back to back.
// - Otherwise conversions keep a fixed period.
// - Transfer clock divided, 2 or 1 MHz, or 1 or 0.5 MHz with OSC4 set.
// - Reset seen flag set after reset.
// - Writing acknowledge clears reset seen flag.
// - Target is eight times programmed value.
//
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`include "tsc_regs.svh"
module tsc_ctrl
  import tsc_pkg::*;
#(
  parameter logic [24:0] WAKE_CYC = 25'(`TSC_WAKE_CYC),
  parameter logic [24:0] SAMPLE_CYC = 25'(`TSC_SAMPLE_CYC)
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic conv_done,
  input wire logic sample_valid,
  input wire logic [3:0] sample_chan,
  input wire logic [15:0] sample_counts,
  input wire logic tune_done,
  input wire logic rdy_force,
  output logic conv_start,
  output logic xfer_tick,
  output logic [1:0] tx_bias,
  output logic prox_projected,
  output logic combined_rx,
  output logic tune_start,
  output logic comm_window,
  output logic low_power,
  output logic conv_halted,
  output logic wake_tick
);
  tsc_ctrl_s s;
  tsc_ctrl_s next_s;
  logic [7:0] xfer_div;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] wmerge(logic [31:0] old, logic [31:0] d, logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] absdiff(logic [15:0] a, logic [15:0] b);
    return (a > b) ? a - b : b - a;
  endfunction

  function automatic logic [15:0] target(logic [7:0] v);
    return {8'h00, v} << `TSC_TGT_SHIFT;
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [3:0] c;
    logic [15:0] lt;
    logic [15:0] cv;
    logic [15:0] tg;
    logic [15:0] bd;
    logic [15:0] drop;
    logic [31:0] wv;
    logic ev;
    logic start_tune;
    c = sample_chan;
    lt = s.long_term_average[sample_chan];
    cv = sample_counts;
    tg = 16'h0000;
    bd = 16'h0000;
    drop = 16'h0000;
    wv = 32'h0;
    ev = 1'b0;
    start_tune = 1'b0;
    next_s = s;
    next_s.conv_start = 1'b0;
    next_s.tune_start = 1'b0;
    next_s.comm_window = 1'b0;
    next_s.wake_tick = 1'b0;
    if (s.period_cnt != 25'h0) begin
      next_s.period_cnt = s.period_cnt - 25'h1;
    end

    // Conversion sequencing.
    unique case (s.state)
      TSC_WAIT: begin
        if (s.set1[`TSC_S1_HALT]) begin
          next_s.state = TSC_HALT;
          next_s.wake_cnt = WAKE_CYC - 25'h1;
        end else if (s.set1[`TSC_S1_FREERUN] || s.period_cnt == 25'h0) begin
          next_s.state = TSC_CONV;
          next_s.conv_start = 1'b1;
          next_s.period_cnt = SAMPLE_CYC - 25'h1;
        end
      end
      TSC_CONV: begin
        if (conv_done) begin
          next_s.state = TSC_WAIT;
          if (!s.tuning || s.set0[`TSC_S0_STREAM]) begin
            next_s.comm_window = 1'b1;
          end
        end
      end
      TSC_HALT: begin
        if (s.wake_cnt == 25'h0) begin
          next_s.wake_cnt = WAKE_CYC - 25'h1;
          next_s.wake_tick = 1'b1;
        end else begin
          next_s.wake_cnt = s.wake_cnt - 25'h1;
        end
        if (!s.set1[`TSC_S1_HALT]) begin
          next_s.state = TSC_WAIT;
        end
      end
    endcase

    if (rdy_force) begin
      next_s.comm_window = 1'b1;
      next_s.low_power = 1'b0;
    end

    // Per-sample filtering and event detection.
    if (sample_valid && sample_chan <= `TSC_LAST_CH) begin
      next_s.cs[c] = cv;
      drop = (lt > cv) ? lt - cv : 16'h0000;
      if (c == 4'h0) begin
        ev = absdiff(cv, lt) > `TSC_PROX_TH;
        next_s.evt[0] = ev;
        next_s.halt_flag = ev;
        if (s.low_power && ev) begin
          next_s.low_power = 1'b0;
          next_s.set1[`TSC_S1_FSLEEP] = 1'b0;
        end
      end else begin
        ev = drop > (lt >> 4);
        next_s.evt[c] = ev;
        next_s.click[c] = s.set0[`TSC_S0_CLICK] && drop > ((lt >> 4) + (lt >> 5));
      end
      // The proximity average is frozen while an event stands so a held hand is not absorbed.
      // average steps toward counts
      if (!(c == 4'h0 && ev)) begin
        if (lt > cv) begin
          next_s.long_term_average[c] = lt - 16'h0001;
        end else if (lt < cv) begin
          next_s.long_term_average[c] = lt + 16'h0001;
        end
      end
      tg = target((c == 4'h0) ? s.tgt[7:0] : s.tgt[15:8]);
      bd = s.set1[`TSC_S1_BAND] ? (tg >> 2) : (tg >> 3);
      if (!ev && (lt > tg + bd || lt + bd < tg)) begin
        start_tune = 1'b1;
      end
    end

    if (s.set0[`TSC_S0_RESEED]) begin
      for (int i = 0; i < 13; i++) begin
        next_s.long_term_average[i] = s.cs[i] + `TSC_RESEED_OFS;
      end
      next_s.evt = 13'h0;
      next_s.set0[`TSC_S0_RESEED] = 1'b0;
    end

    if (s.set0[`TSC_S0_RETUNE]) begin
      start_tune = 1'b1;
    end
    if (start_tune && !s.tuning) begin
      next_s.tuning = 1'b1;
      next_s.tune_start = 1'b1;
      next_s.set0[`TSC_S0_RETUNE] = 1'b0;
      next_s.evt = 13'h0;
      next_s.click = 13'h0;
      next_s.halt_flag = 1'b0;
    end else if (s.tuning && tune_done) begin
      next_s.tuning = 1'b0;
    end

    // ****************************************
    // AXI4-Lite write channel
    // ****************************************
    if (awvalid && awready) begin
      next_s.aw_got = 1'b1;
      next_s.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_s.w_got = 1'b1;
      next_s.w_data = wdata;
      next_s.w_strb = wstrb;
    end
    if (bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    // The write lands after the hardware updates so a host set beats a same-cycle clear.
    if (s.aw_got && s.w_got && !s.bvalid) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = `TSC_RESP_OK;
      unique case ({s.aw_addr[7:2], 2'b00})
        `TSC_OFS_SET0: begin
          wv = wmerge({24'h0, s.set0}, s.w_data, s.w_strb);
          next_s.set0 = wv[7:0];
        end
        `TSC_OFS_SET1: begin
          wv = wmerge({16'h0, s.set1}, s.w_data, s.w_strb);
          if (wv[`TSC_S1_ACK]) begin
            next_s.reset_seen = 1'b0;
          end
          wv[`TSC_S1_ACK] = 1'b0;
          if (wv[`TSC_S1_FSLEEP] && !s.set1[`TSC_S1_FSLEEP]) begin
            next_s.long_term_average[0] = s.cs[0] + `TSC_RESEED_OFS;
            next_s.evt[0] = 1'b0;
            next_s.low_power = 1'b1;
          end
          next_s.set1 = wv[15:0];
        end
        `TSC_OFS_TGT: begin
          wv = wmerge({16'h0, s.tgt}, s.w_data, s.w_strb);
          next_s.tgt = wv[15:0];
        end
        `TSC_OFS_SYSF, `TSC_OFS_STAT: begin
          next_s.bresp = `TSC_RESP_OK;
        end
        default: begin
          next_s.bresp = `TSC_RESP_ERR;
        end
      endcase
    end

    // ****************************************
    // AXI4-Lite read channel
    // ****************************************
    if (rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = `TSC_RESP_OK;
      unique case ({araddr[7:2], 2'b00})
        `TSC_OFS_SET0: next_s.rdata = {24'h0, s.set0};
        `TSC_OFS_SET1: next_s.rdata = {16'h0, s.set1};
        `TSC_OFS_SYSF: next_s.rdata = {28'h0, s.low_power, s.state == TSC_HALT, s.tuning, s.reset_seen};
        `TSC_OFS_TGT: next_s.rdata = {16'h0, s.tgt};
        `TSC_OFS_STAT: next_s.rdata = {3'h0, s.click, 2'h0, s.halt_flag, s.evt};
        default: begin
          next_s.rdata = 32'h0;
          next_s.rresp = `TSC_RESP_ERR;
        end
      endcase
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.reset_seen <= 1'b1;
      s.set0 <= `TSC_SET0_RST;
      s.set1 <= `TSC_SET1_RST;
      s.tgt <= `TSC_TGT_RST;
      s.state <= TSC_WAIT;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // Charge transfer clock
  // ****************************************
  // divider from speed and oscillator
  always_comb begin
    xfer_div = (s.set1[`TSC_S1_SPEED_HI:`TSC_S1_SPEED_LO] == `TSC_SPEED_FAST) ? 8'(`TSC_DIV_FAST) : 8'(`TSC_DIV_SLOW);
    if (s.set1[`TSC_S1_OSC4]) begin
      xfer_div = {xfer_div[6:0], 1'b0};
    end
  end

  tsc_xfer_div u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(s.state == TSC_CONV),
    .div(xfer_div),
    .tick(xfer_tick)
  );

  assign awready = !s.aw_got && !s.bvalid;
  assign wready = !s.w_got && !s.bvalid;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = !s.rvalid;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign conv_start = s.conv_start;
  assign tune_start = s.tune_start;
  assign comm_window = s.comm_window;
  assign wake_tick = s.wake_tick;
  assign low_power = s.low_power;
  assign conv_halted = s.state == TSC_HALT;
  assign tx_bias = s.set0[`TSC_S0_BIAS_HI:`TSC_S0_BIAS_LO];
  assign prox_projected = s.set1[`TSC_S1_PPROJ];
  assign combined_rx = s.set1[`TSC_S1_COMBRX];
endmodule

// *** hw/tsc_regs.svh ***
// Register offsets, field positions, reset values and timing counts of the touch settings block.
`ifndef TSC_REGS_SVH
`define TSC_REGS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define TSC_OFS_SET0 8'h00
`define TSC_OFS_SET1 8'h04
`define TSC_OFS_SYSF 8'h08
`define TSC_OFS_TGT 8'h0c
`define TSC_OFS_STAT 8'h10
// ****************************************
// Field positions
// ****************************************
`define TSC_S0_BIAS_LO 0
`define TSC_S0_BIAS_HI 1
`define TSC_S0_STREAM 2
`define TSC_S0_RESEED 3
`define TSC_S0_RETUNE 4
`define TSC_S0_CLICK 5
`define TSC_S1_BAND 0
`define TSC_S1_FSLEEP 1
`define TSC_S1_PPROJ 2
`define TSC_S1_HALT 3
`define TSC_S1_FREERUN 4
`define TSC_S1_SPEED_LO 5
`define TSC_S1_SPEED_HI 6
`define TSC_S1_ACK 7
`define TSC_S1_COMBRX 8
`define TSC_S1_OSC4 9
// ****************************************
// Reset values and constants
// ****************************************
`define TSC_SET0_RST 8'h00
`define TSC_SET1_RST 16'h0000
`define TSC_TGT_RST 16'h2040
`define TSC_SPEED_FAST 2'h0
`define TSC_LAST_CH 4'hc
`define TSC_RESEED_OFS 16'h0008
`define TSC_PROX_TH 16'h0010
`define TSC_TGT_SHIFT 3
`define TSC_RESP_OK 2'h0
`define TSC_RESP_ERR 2'h2
// ****************************************
// Timing
// ****************************************
`define TSC_CLK_HZ 50000000
`define TSC_WAKE_MS 512
`define TSC_WAKE_CYC (`TSC_WAKE_MS * (`TSC_CLK_HZ / 1000))
`define TSC_SAMPLE_MS 16
`define TSC_SAMPLE_CYC (`TSC_SAMPLE_MS * (`TSC_CLK_HZ / 1000))
`define TSC_XFER_FAST_HZ 2000000
`define TSC_XFER_SLOW_HZ 1000000
`define TSC_DIV_FAST (`TSC_CLK_HZ / `TSC_XFER_FAST_HZ)
`define TSC_DIV_SLOW (`TSC_CLK_HZ / `TSC_XFER_SLOW_HZ)
`endif

// *** hw/tsc_pkg.sv ***
// Types shared by the touch settings block.
package tsc_pkg;
  typedef enum logic [1:0] {TSC_WAIT, TSC_CONV, TSC_HALT} tsc_state_e;
  typedef struct packed {
    tsc_state_e state;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] set0;
    logic [15:0] set1;
    logic [15:0] tgt;
    logic reset_seen;
    logic low_power;
    logic tuning;
    logic halt_flag;
    logic [12:0] evt;
    logic [12:0] click;
    logic [12:0][15:0] long_term_average;
    logic [12:0][15:0] cs;
    logic [24:0] period_cnt;
    logic [24:0] wake_cnt;
    logic conv_start;
    logic tune_start;
    logic comm_window;
    logic wake_tick;
  } tsc_ctrl_s;
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } tsc_div_s;
endpackage

// *** hw/tsc_xfer_div.sv ***
// Charge transfer rate divider producing a one-cycle enable pulse.
module tsc_xfer_div
  import tsc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [7:0] div,
  output logic tick
);
  tsc_div_s s;
  tsc_div_s next_s;

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (!run) begin
      next_s.cnt = 8'h00;
    end else if (s.cnt >= div - 8'h01) begin
      next_s.cnt = 8'h00;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;
endmodule

// *** dv/tsc_props.sv ***
// Concurrent checks on the ports of the touch settings block.
module tsc_props #(
  parameter logic [24:0] WAKE_CYC = 25'd40
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic [1:0] tx_bias,
  input wire logic prox_projected,
  input wire logic combined_rx,
  input wire logic rdy_force,
  input wire logic comm_window,
  input wire logic low_power,
  input wire logic conv_halted,
  input wire logic conv_start,
  input wire logic xfer_tick,
  input wire logic wake_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Port checks
  // ****************************************
  logic [24:0] hcnt;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // A lost wake tick shows up as this count running past the wake period.
  always_ff @(posedge aclk) begin
    if (!aresetn || !conv_halted || wake_tick) begin
      hcnt <= 25'h0;
    end else begin
      hcnt <= hcnt + 25'h1;
    end
  end
  // Both halves are held one cycle before the write lands and bvalid rises.
  property p_wr_resp; awvalid && awready && wvalid && wready |-> ##2 bvalid; endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write not answered");
  property p_rd_resp; arvalid && arready |=> rvalid; endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read not answered");
  property p_cfg; $changed({tx_bias, prox_projected, combined_rx}) |-> bvalid || $past(bvalid); endproperty
  a_cfg: assert property (p_cfg) else $error("settings output moved without a write");
  property p_force; rdy_force |=> comm_window; endproperty
  a_force: assert property (p_force) else $error("handshake gave no window");
  property p_lp; rdy_force |-> ##[1:2] !low_power; endproperty
  a_lp: assert property (p_lp) else $error("handshake left low power on");
  property p_halt; conv_halted |-> !conv_start && !xfer_tick; endproperty
  a_halt: assert property (p_halt) else $error("conversion activity while halted");
  property p_wake; hcnt <= WAKE_CYC; endproperty
  a_wake: assert property (p_wake) else $error("wake tick overdue");
  property p_wtick; wake_tick |-> conv_halted || $past(conv_halted); endproperty
  a_wtick: assert property (p_wtick) else $error("wake tick outside halt");
  property p_pulse; conv_start |=> !conv_start [*8]; endproperty
  a_pulse: assert property (p_pulse) else $error("conversion restarted too early");
  c_force: cover property (rdy_force ##1 comm_window);
  c_wake: cover property (wake_tick);
  c_write: cover property (bvalid && bready);
endmodule
bind tsc_ctrl tsc_props #(.WAKE_CYC(WAKE_CYC)) u_props (.*);

// *** dv/tsc_afe_model.sv ***
// Behavioural analogue sense engine answering conversion and tuning requests.
module tsc_afe_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic conv_start,
  input wire logic tune_start,
  input wire logic [15:0] prox_cnt,
  input wire logic [15:0] touch_cnt,
  input wire logic slow,
  input wire logic [7:0] tune_dly,
  output logic conv_done = 1'b0,
  output logic sample_valid = 1'b0,
  output logic [3:0] sample_chan = 4'h0,
  output logic [15:0] sample_counts = 16'h0,
  output logic tune_done = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Engine sequencing
  // ****************************************
  int step = 0;
  int tcnt = 0;
  // Idle counts toggle every cycle so a sample taken outside its strobe is caught.
  always @(posedge aclk) begin
    sample_valid <= 1'b0;
    conv_done <= 1'b0;
    tune_done <= 1'b0;
    sample_counts <= ~sample_counts;
    if (!aresetn) begin
      step <= 0;
      tcnt <= 0;
    end else begin
      if (conv_start) step <= 1;
      else if (step > 0) step <= step + 1;
      if (step >= 1 && step <= 13) begin
        sample_valid <= 1'b1;
        sample_chan <= 4'(step - 1);
        sample_counts <= (step == 1) ? prox_cnt : touch_cnt;
      end
      // Slow conversions outlast the longest transfer divider so a whole tick gap is seen.
      if (step >= (slow ? 110 : 15)) begin
        conv_done <= 1'b1;
        step <= 0;
      end
      if (tune_start) tcnt <= int'(tune_dly);
      else if (tcnt > 0) tcnt <= tcnt - 1;
      if (tcnt == 1) tune_done <= 1'b1;
    end
  end
endmodule

// *** dv/tb.sv ***
// Self-checking bench for the touch settings block.
`include "tsc_regs.svh"
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin fail_count++; $display("unexpected %s exp %h got %h", n, e, s); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Stimulus and checking
  // ****************************************
  logic aclk = 1'b0;
  logic aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic rdy_force = 1'b0, slow = 1'b0, in_tune = 1'b0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0, tune_dly = 8'h50;
  logic [31:0] wdata = 32'h0, seed = 32'h4dfd27c7, rd, ex, rdata;
  logic [3:0] wstrb = 4'hf, sample_chan;
  logic [15:0] prox_cnt = 16'h0200, touch_cnt = 16'h0100, sample_counts;
  logic [1:0] bresp, rresp, rsp, tx_bias;
  logic awready, wready, bvalid, arready, rvalid, conv_done, sample_valid, tune_done, conv_start, xfer_tick;
  logic prox_projected, combined_rx, tune_start, comm_window, low_power, conv_halted, wake_tick;
  logic [31:0] mdl [5];
  int fail_count = 0, compares = 0, cw_cnt = 0, wk_cnt = 0, conv_cnt = 0, ts_cnt = 0, lt, dr;
  int tk_cnt = 0, tk_gap = 0;
  tsc_ctrl #(.WAKE_CYC(25'd40), .SAMPLE_CYC(25'd20)) u_dut (.*);
  tsc_afe_model u_afe (.*);
  always #10 aclk = ~aclk;
  always @(posedge aclk) begin
    if (tune_start) in_tune <= 1'b1;
    else if (tune_done) in_tune <= 1'b0;
    if (in_tune && comm_window) cw_cnt++;
    if (wake_tick) wk_cnt++;
    if (conv_done) conv_cnt++;
    if (tune_start) ts_cnt++;
    if (conv_start || xfer_tick) tk_cnt <= 1;
    else tk_cnt <= tk_cnt + 1;
    if (xfer_tick) tk_gap <= tk_cnt;
  end
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rchk(input int i, input logic [31:0] m);
    axr(8'(i * 4), rd, rsp);
    `CHK("register", mdl[i] & m, rd & m)
  endtask
  task automatic settle(input int n);
    int c0;
    c0 = conv_cnt;
    wait (conv_cnt >= c0 + n);
    @(posedge aclk);
  endtask
  // The retune and reseed bits clear themselves, so the model keeps only the sticky bits.
  task automatic retune(input logic [31:0] d, input logic pulse);
    cw_cnt = 0;
    mdl[0] = d & 32'he7;
    axw(`TSC_OFS_SET0, d, rsp);
    for (int n = 0; n < 200 && !tune_start; n++) @(posedge aclk);
    `CHK("tune start", 1'b1, tune_start)
    @(posedge aclk);
    rdy_force <= pulse;
    @(posedge aclk);
    rdy_force <= 1'b0;
    wait (!in_tune);
    @(posedge aclk);
    rchk(0, 32'hff);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #(20 * 30000);
    fail_count++;
    $display("unexpected run length exp finished got hung");
    test_done();
  end
  initial begin
    mdl = '{32'h0, 32'h0, 32'h1, 32'(`TSC_TGT_RST), 32'h0};
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 4; i++) rchk(i, (i == 2) ? 32'h1 : 32'hffffffff);
    // Averages leave reset at zero, so seed them from real counts to stop endless retuning.
    settle(1);
    axw(`TSC_OFS_SET0, 32'h08, rsp);
    wait (!in_tune);
    for (int i = 0; i < 8; i++) begin
      seed = nx(seed);
      slow <= 1'b1;
      mdl[0] = (seed & 32'h24) | 32'(i % 4);
      mdl[1] = (seed >> 8) & 32'h375;
      axw(`TSC_OFS_SET0, mdl[0], rsp);
      axw(`TSC_OFS_SET1, mdl[1], rsp);
      rchk(0, 32'hff);
      rchk(1, 32'hffff);
      `CHK("bias", mdl[0][1:0], tx_bias)
      `CHK("charging", {mdl[1][8], mdl[1][2]}, {combined_rx, prox_projected})
      // The second conversion starts after the write, so its tick gap uses the new rate.
      settle(2);
      `CHK("transfer rate", ((mdl[1][6:5] == 2'h0) ? `TSC_DIV_FAST : `TSC_DIV_SLOW) << mdl[1][9], tk_gap)
    end
    slow <= 1'b0;
    mdl[1] = 32'h0;
    mdl[2] = 32'h0;
    axw(`TSC_OFS_SET1, 32'h80, rsp);
    rchk(2, 32'h1);
    rchk(1, 32'hffff);
    axw(8'h14, 32'hffffffff, rsp);
    `CHK("unmapped write", 2'(`TSC_RESP_ERR), rsp)
    axr(8'h14, rd, rsp);
    `CHK("unmapped read", {2'(`TSC_RESP_ERR), 32'h0}, {rsp, rd})
    retune(32'h10, 1'b1);
    `CHK("tuning windows", 1'b1, 1'(cw_cnt == 1))
    retune(32'h14, 1'b0);
    `CHK("streamed windows", 1'b1, 1'(cw_cnt > 0))
    axw(`TSC_OFS_SET0, 32'h20, rsp);
    touch_cnt <= 16'h00c8;
    settle(3);
    lt = 8 * int'(`TSC_TGT_RST >> 8);
    dr = lt - 200;
    ex = ((dr * 16 > lt) ? 32'h1ffe : 32'h0) | ((dr * 32 > lt * 3) ? 32'h1ffe0000 : 32'h0);
    axr(`TSC_OFS_STAT, rd, rsp);
    `CHK("touch and click", ex, rd & 32'h1fff1fff)
    retune(32'h28, 1'b0);
    rchk(4, 32'h1fff);
    mdl[1] = 32'h1;
    axw(`TSC_OFS_SET1, mdl[1], rsp);
    wait (!in_tune);
    repeat (30) @(posedge aclk);
    ts_cnt = 0;
    settle(4);
    `CHK("quarter band", 0, ts_cnt)
    axw(`TSC_OFS_SET1, 32'h03, rsp);
    repeat (3) @(posedge aclk);
    `CHK("sleep", 1'b1, low_power)
    rdy_force <= 1'b1;
    @(posedge aclk);
    rdy_force <= 1'b0;
    repeat (2) @(posedge aclk);
    `CHK("sleep cancel", 1'b0, low_power)
    axw(`TSC_OFS_SET1, 32'h09, rsp);
    wk_cnt = 0;
    repeat (100) @(posedge aclk);
    `CHK("halted", 1'b1, conv_halted)
    `CHK("wake ticks", 1'b1, 1'(wk_cnt >= 2 && wk_cnt <= 3))
    axw(`TSC_OFS_SET1, 32'h01, rsp);
    settle(2);
    `CHK("resumed", 1'b0, conv_halted)
    test_done();
  end
endmodule
